// file: rtl/watchdog_pkg.sv
// Constants for the software watchdog: register map, field layout, reset values and count exponents.
package watchdog_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int CNT_W = 20;
	localparam int PER_W = 3;
	localparam int EXP_W = 5;
	localparam int IRQ_W = 2;

	// Register byte addresses.
	localparam logic [ADDR_W-1:0] ADDR_CAUSE = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_OPTIONS = 8'h01;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h02;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h03;
	localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h04;

	// Layout of system_options_one.
	localparam int OPT_EN_BIT = 7;
	localparam int OPT_CLK_BIT = 3;
	localparam int OPT_PER_LSB = 0;
	localparam logic [DATA_W-1:0] OPT_WRITABLE = 8'h8f;
	localparam logic [DATA_W-1:0] OPT_RESET = 8'h8f;

	// Layout of reset_cause_register.
	localparam int CAUSE_POR_BIT = 7;
	localparam int CAUSE_WDOG_BIT = 5;
	localparam logic [DATA_W-1:0] CAUSE_POR = 8'h80;
	localparam logic [DATA_W-1:0] CAUSE_WDOG = 8'h20;

	// Interrupt status and mask layout.
	localparam int IRQ_TIMEOUT_BIT = 0;
	localparam int IRQ_LOCKED_BIT = 1;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

	// Layout of the state register.
	localparam int STATE_LOCK_BIT = 0;
	localparam int STATE_RUN_BIT = 1;

	// Overflow count exponents for each clock source.
	localparam logic [EXP_W-1:0] LFO_EXP_BASE = 5'h05;
	localparam logic [EXP_W-1:0] LFO_EXP_MAX = 5'h0b;
	localparam logic [EXP_W-1:0] BUS_EXP_BASE = 5'h0d;
	localparam logic [EXP_W-1:0] BUS_EXP_MAX = 5'h13;

	localparam logic CLK_SEL_LFO = 1'b0;
	localparam logic CLK_SEL_BUS = 1'b1;

endpackage : watchdog_pkg

// file: rtl/software_watchdog.sv
// Software watchdog: counter, write-once options, reset cause, interrupts and register port.

module software_watchdog
	import watchdog_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata_q,
	input wire logic low_freq_oscillator,
	input wire logic debug_active,
	output logic system_reset_q,
	output logic irq_q
);

	// Overflow exponent for a source and period code; used by the counter, while lfo_limit_a and bus_limit_a recompute the count.
	function automatic logic [EXP_W-1:0] overflow_exp(input logic clk_sel, input logic [PER_W-1:0] per);
		logic [EXP_W-1:0] base;
		logic [EXP_W-1:0] top;
		logic [EXP_W-1:0] sum;
		base = (clk_sel == CLK_SEL_BUS) ? BUS_EXP_BASE : LFO_EXP_BASE;
		top = (clk_sel == CLK_SEL_BUS) ? BUS_EXP_MAX : LFO_EXP_MAX;
		sum = base + {{(EXP_W-PER_W){1'b0}}, per};
		return (sum > top) ? top : sum;
	endfunction

	logic lfo_meta_q;
	logic lfo_sync_q;
	logic lfo_prev_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [DATA_W-1:0] opt_q;
	logic [DATA_W-1:0] opt_d;
	logic locked_q;
	logic locked_d;
	logic [DATA_W-1:0] cause_q;
	logic [DATA_W-1:0] cause_d;
	logic [IRQ_W-1:0] status_q;
	logic [IRQ_W-1:0] status_d;
	logic [IRQ_W-1:0] mask_q;
	logic [IRQ_W-1:0] mask_d;
	logic [DATA_W-1:0] rdata_d;

	wire logic lfo_tick;
	wire logic opt_en;
	wire logic opt_clk;
	wire logic [PER_W-1:0] opt_per;
	wire logic [EXP_W-1:0] cur_exp;
	wire logic [CNT_W-1:0] limit_m1;
	wire logic src_tick;
	wire logic run;
	wire logic hit;
	wire logic svc_wr;
	wire logic opt_wr;
	wire logic opt_take;
	wire logic opt_refused;
	wire logic status_wr;
	wire logic mask_wr;
	wire logic [IRQ_W-1:0] events;
	wire logic [IRQ_W-1:0] status_clr;
	wire logic [DATA_W-1:0] state_view;
	wire logic [DATA_W-1:0] rd_mux;

	// The oscillator arrives from another domain; only the second stage feeds the edge detector.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lfo_meta_q <= 1'b0;
			lfo_sync_q <= 1'b0;
			lfo_prev_q <= 1'b0;
		end else begin
			lfo_meta_q <= low_freq_oscillator;
			lfo_sync_q <= lfo_meta_q;
			lfo_prev_q <= lfo_sync_q;
		end
	end

	assign lfo_tick = lfo_sync_q & ~lfo_prev_q;

	assign opt_en = opt_q[OPT_EN_BIT];
	assign opt_clk = opt_q[OPT_CLK_BIT];
	assign opt_per = opt_q[OPT_PER_LSB +: PER_W];

	// Bus source counts every ref_clk edge; the oscillator source counts its rising edges.
	assign src_tick = (opt_clk == CLK_SEL_BUS) ? 1'b1 : lfo_tick;
	assign cur_exp = overflow_exp(opt_clk, opt_per);
	assign limit_m1 = ~({CNT_W{1'b1}} << cur_exp);
	assign run = opt_en & ~debug_active;
	// A timeout beats a service write in the same cycle: the overflow count was already reached.
	assign hit = run & src_tick & (cnt_q == limit_m1);

	assign svc_wr = reg_wr & (reg_addr == ADDR_CAUSE);
	assign opt_wr = reg_wr & (reg_addr == ADDR_OPTIONS);
	assign opt_take = opt_wr & ~locked_q & ~hit;
	assign opt_refused = opt_wr & locked_q & ~hit;
	assign status_wr = reg_wr & (reg_addr == ADDR_IRQ_STATUS);
	assign mask_wr = reg_wr & (reg_addr == ADDR_IRQ_MASK);

	// Counter next value: cleared on timeout, service or disable, else advanced per tick unless debug_active holds it.
	always_comb begin
		if (hit || svc_wr || !opt_en) begin
			cnt_d = '0;
		end else if (run && src_tick) begin
			cnt_d = cnt_q + CNT_W'(1);
		end else begin
			cnt_d = cnt_q;
		end
	end

	// A timeout restores the power-up options and unlocks them, as any reset does.
	// An options write does not restart the counter, so a shorter period must be chosen early.
	// A counter already past the new limit would otherwise wrap before it times out.
	assign opt_d = hit ? OPT_RESET : (opt_take ? (reg_wdata & OPT_WRITABLE) : opt_q);
	assign locked_d = hit ? 1'b0 : (locked_q | opt_take);

	// The service write is not a data write: only a timeout changes the cause.
	assign cause_d = hit ? CAUSE_WDOG : cause_q;

	// Sticky events; a new event wins over a write-one-to-clear in the same cycle.
	assign events[IRQ_TIMEOUT_BIT] = hit;
	assign events[IRQ_LOCKED_BIT] = opt_refused;
	assign status_clr = status_wr ? reg_wdata[IRQ_W-1:0] : '0;
	for (genvar i = 0; i < IRQ_W; i++) begin : g_status
		assign status_d[i] = events[i] | (status_q[i] & ~status_clr[i]);
	end
	assign mask_d = mask_wr ? reg_wdata[IRQ_W-1:0] : mask_q;

	assign state_view = DATA_W'({run, locked_q}) << STATE_LOCK_BIT;

	assign rd_mux = (reg_addr == ADDR_CAUSE) ? cause_q :
		(reg_addr == ADDR_OPTIONS) ? opt_q :
		(reg_addr == ADDR_IRQ_STATUS) ? DATA_W'(status_q) :
		(reg_addr == ADDR_IRQ_MASK) ? DATA_W'(mask_q) :
		(reg_addr == ADDR_STATE) ? state_view : '0;
	assign rdata_d = reg_rd ? rd_mux : '0;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= '0;
			opt_q <= OPT_RESET;
			locked_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			opt_q <= opt_d;
			locked_q <= locked_d;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cause_q <= CAUSE_POR;
			status_q <= '0;
			mask_q <= IRQ_MASK_RESET;
		end else begin
			cause_q <= cause_d;
			status_q <= status_d;
			mask_q <= mask_d;
		end
	end

	// The interrupt output is registered from the next status and mask, so it matches status_q with no lag and leaves a flip-flop.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata_q <= '0;
			system_reset_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			reg_rdata_q <= rdata_d;
			system_reset_q <= hit;
			irq_q <= |(status_d & mask_d);
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	disabled_no_count_a: assert property (
		!opt_en |=> (cnt_q == '0) && !system_reset_q
	) else $error("Counter or reset moved while the watchdog was disabled.");

	service_restart_a: assert property (
		svc_wr |=> (cnt_q == '0)
	) else $error("Service write did not restart the counter.");

	cause_kept_a: assert property (
		svc_wr && !hit |=> $stable(cause_q)
	) else $error("Service write altered the reset cause.");

	reset_on_overflow_a: assert property (
		system_reset_q |-> $past(run) && $past(src_tick) && ($past(cnt_q) == $past(limit_m1))
	) else $error("System reset without a counter overflow.");

	bus_source_step_a: assert property (
		run && opt_clk && !svc_wr && !hit |=> cnt_q == $past(cnt_q) + CNT_W'(1)
	) else $error("Bus source did not advance the counter each cycle.");

	lfo_source_hold_a: assert property (
		run && !opt_clk && !lfo_tick && !svc_wr |=> $stable(cnt_q)
	) else $error("Oscillator source advanced without a tick.");

	lfo_limit_a: assert property (
		hit && !opt_clk |-> cnt_q + CNT_W'(1) == (CNT_W'(1) << ((opt_per >= 3'h6) ? 11 : 5 + int'(opt_per)))
	) else $error("Oscillator overflow count is wrong.");

	bus_limit_a: assert property (
		hit && opt_clk |-> cnt_q + CNT_W'(1) == (CNT_W'(1) << ((opt_per == 3'h7) ? 19 : 13 + int'(opt_per)))
	) else $error("Bus overflow count is wrong.");

	timeout_defaults_a: assert property (
		system_reset_q |-> (opt_q == OPT_RESET) && !locked_q && (cnt_q == '0)
	) else $error("Timeout did not restore the default settings.");

	write_once_a: assert property (
		locked_q && !hit ##1 locked_q |-> $stable(opt_q)
	) else $error("Locked options changed.");

	debug_freeze_a: assert property (
		debug_active && !svc_wr |=> $stable(cnt_q) && !system_reset_q
	) else $error("Counter moved during debug mode.");

	cause_record_a: assert property (
		system_reset_q |-> cause_q[CAUSE_WDOG_BIT] && !cause_q[CAUSE_POR_BIT]
	) else $error("Timeout not recorded in the reset cause.");

	// The checks below, except irq_level_a and lfo_sync_path_a, follow each event one cycle on, where its registered effect must show.
	// They watch the internal decode so that a broken path fails close to its cause.
	reset_single_pulse_a: assert property (
		system_reset_q
		|=> !system_reset_q
	) else $error("System reset pulse lasted more than one cycle.");

	timeout_cause_set_a: assert property (
		hit
		|=> cause_q == CAUSE_WDOG
	) else $error("Timeout did not load the watchdog cause.");

	timeout_unlocks_a: assert property (
		hit
		|=> !locked_q && (opt_q == OPT_RESET)
	) else $error("Timeout did not unlock and restore the options.");

	timeout_count_zero_a: assert property (
		hit
		|=> cnt_q == '0
	) else $error("Counter not cleared after a timeout.");

	take_locks_a: assert property (
		opt_take
		|=> locked_q
	) else $error("Accepted options write did not lock the register.");

	take_value_a: assert property (
		opt_take
		|=> opt_q == ($past(reg_wdata) & OPT_WRITABLE)
	) else $error("Accepted options write stored a wrong value.");

	locked_hold_a: assert property (
		locked_q && !hit
		|=> locked_q
	) else $error("Options lock dropped without a timeout.");

	refused_flag_a: assert property (
		opt_refused
		|=> status_q[IRQ_LOCKED_BIT]
	) else $error("Refused options write not flagged.");

	timeout_flag_a: assert property (
		hit
		|=> status_q[IRQ_TIMEOUT_BIT]
	) else $error("Timeout not flagged in the status.");

	status_clear_a: assert property (
		status_wr && reg_wdata[IRQ_TIMEOUT_BIT] && !hit
		|=> !status_q[IRQ_TIMEOUT_BIT]
	) else $error("Write of one did not clear the timeout flag.");

	mask_write_a: assert property (
		mask_wr
		|=> DATA_W'(mask_q) == ($past(reg_wdata) & DATA_W'({IRQ_W{1'b1}}))
	) else $error("Mask write stored a wrong value.");

	irq_level_a: assert property (
		irq_q
		== (|(status_q & mask_q))
	) else $error("Interrupt output does not follow the unmasked status.");

	lfo_source_step_a: assert property (
		run && !opt_clk && lfo_tick && !svc_wr && !hit
		|=> cnt_q == $past(cnt_q) + CNT_W'(1)
	) else $error("Oscillator tick did not advance the counter.");

	lfo_sync_path_a: assert property (
		lfo_tick
		|-> $past(lfo_meta_q)
	) else $error("Oscillator tick without passing both sync stages.");

	cause_only_timeout_a: assert property (
		!hit
		|=> $stable(cause_q)
	) else $error("Reset cause changed without a timeout.");

	cause_read_a: assert property (
		reg_rd && (reg_addr == ADDR_CAUSE)
		|=> reg_rdata_q == $past(cause_q)
	) else $error("Reset cause read back a wrong value.");

	read_idle_zero_a: assert property (
		!reg_rd
		|=> reg_rdata_q == '0
	) else $error("Read data not zero outside a read.");

	debug_no_reset_a: assert property (
		debug_active
		|=> !system_reset_q
	) else $error("System reset raised during debug mode.");

	timeout_cover: cover property (system_reset_q);
	refused_write_cover: cover property (opt_refused);
	service_cover: cover property (run && (cnt_q != '0) ##1 svc_wr);
	irq_cover: cover property (irq_q);
	lfo_timeout_cover: cover property (hit && !opt_clk);

endmodule // software_watchdog

// file: test/cpu_model.sv
// Bus master model of the CPU that issues single register reads and writes.
module cpu_model
	import watchdog_pkg::*;
(
	input wire logic ref_clk,
	input wire logic [DATA_W-1:0] reg_rdata_q,
	output logic [ADDR_W-1:0] reg_addr,
	output logic [DATA_W-1:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// Address and data are inverted after release so nothing can lean on stale bus values.
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		// The read data stand for this one cycle only; take them where they are settled.
		@(negedge ref_clk);
		d = reg_rdata_q;
		@(posedge ref_clk);
	endtask
endmodule // cpu_model

// file: test/testbench.sv
// Self-checking testbench for the software watchdog.
module testbench
	import watchdog_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic ref_clk, sys_rst, reg_wr, reg_rd, osc_pin, debug_active, system_reset_q, irq_q, osc_en, ph;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata_q;
	int err_count, n_tests, ticks, n, t0, exp_t;

	software_watchdog dut(.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .low_freq_oscillator(osc_pin),
		.debug_active(debug_active), .system_reset_q(system_reset_q), .irq_q(irq_q));
	cpu_model cpu(.ref_clk(ref_clk), .reg_rdata_q(reg_rdata_q), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd));

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// Oscillator pin of four clock periods; ticks counts its rising edges.
	always @(posedge ref_clk) begin
		ph <= ~ph;
		if (!osc_en) begin
			osc_pin <= 1'b0;
		end else if (ph) begin
			osc_pin <= ~osc_pin;
			if (!osc_pin) begin
				ticks <= ticks + 1;
			end
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("mismatches %0d of %0d checks", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		logic [DATA_W-1:0] d;
		cpu.rd(a, d);
		chk(d, e);
	endtask

	// Returns the edge count at which the reset pulse was sampled, or 0 when none came.
	task automatic wait_rst(input int lim, input bit must, output int cnt);
		cnt = 0;
		for (int i = 1; i <= lim && cnt == 0; i++) begin
			@(negedge ref_clk);
			if (system_reset_q === 1'b1) begin
				cnt = i;
			end
		end
		@(posedge ref_clk);
		if (must && cnt == 0) begin
			chk(1'b0, 1'b1);
			end_sim();
		end
	endtask

	task automatic check_defaults();
		rdchk(ADDR_CAUSE, CAUSE_POR);
		rdchk(ADDR_OPTIONS, OPT_RESET);
		rdchk(ADDR_STATE, 8'h02);
		rdchk(8'h10, 8'h00);
		chk(irq_q, 1'b0);
	endtask

	task automatic lock_and_irq();
		cpu.wr(ADDR_OPTIONS, 8'h88);
		cpu.wr(ADDR_OPTIONS, 8'h8f);
		rdchk(ADDR_OPTIONS, 8'h88);
		rdchk(ADDR_IRQ_STATUS, 8'h02);
		chk(irq_q, 1'b0);
		cpu.wr(ADDR_IRQ_MASK, 8'h03);
		repeat (3) @(posedge ref_clk);
		chk(irq_q, 1'b1);
		cpu.wr(ADDR_IRQ_STATUS, 8'h02);
		repeat (3) @(posedge ref_clk);
		chk(irq_q, 1'b0);
		rdchk(ADDR_STATE, 8'h03);
	endtask

	task automatic service_keeps();
		for (int i = 0; i < 3; i++) begin
			cpu.wr(ADDR_CAUSE, 8'h5a + 8'(i));
			wait_rst(6000, 1'b0, n);
			chk(n, 0);
		end
		rdchk(ADDR_CAUSE, CAUSE_POR);
	endtask

	task automatic debug_freeze();
		cpu.wr(ADDR_CAUSE, 8'h00);
		debug_active <= 1'b1;
		wait_rst(9000, 1'b0, n);
		chk(n, 0);
		debug_active <= 1'b0;
		wait_rst(8200, 1'b1, n);
	endtask

	// Edge after the service write plus the overflow count; the last of these edges samples the reset.
	task automatic timeout_exact();
		rdchk(ADDR_OPTIONS, OPT_RESET);
		cpu.wr(ADDR_IRQ_STATUS, 8'h03);
		cpu.wr(ADDR_OPTIONS, 8'h88);
		cpu.wr(ADDR_CAUSE, 8'h00);
		wait_rst(9000, 1'b1, n);
		chk(n, 8193);
		rdchk(ADDR_CAUSE, CAUSE_WDOG);
		rdchk(ADDR_IRQ_STATUS, 8'h01);
		chk(irq_q, 1'b1);
	endtask

	task automatic disabled_quiet();
		cpu.wr(ADDR_OPTIONS, 8'h08);
		wait_rst(9000, 1'b0, n);
		chk(n, 0);
		rdchk(ADDR_STATE, 8'h01);
	endtask

	task automatic osc_periods();
		osc_en <= 1'b1;
		for (int c = 0; c < 8; c++) begin
			sys_rst <= 1'b1;
			repeat (5) @(posedge ref_clk);
			sys_rst <= 1'b0;
			cpu.wr(ADDR_OPTIONS, 8'h80 + 8'(c));
			cpu.wr(ADDR_CAUSE, 8'h00);
			t0 = ticks;
			exp_t = 1 << ((c < 6) ? 5 + c : 11);
			wait_rst(10000, 1'b1, n);
			chk((ticks - t0 >= exp_t - 1) && (ticks - t0 <= exp_t + 2), 1'b1);
		end
	endtask

	initial begin
		sys_rst = 1'b1;
		debug_active = 1'b0;
		osc_en = 1'b0;
		osc_pin = 1'b0;
		ph = 1'b0;
		ticks = 0;
		err_count = 0;
		n_tests = 0;
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		check_defaults();
		lock_and_irq();
		service_keeps();
		debug_freeze();
		timeout_exact();
		disabled_quiet();
		osc_periods();
		end_sim();
	end
endmodule // testbench
